// ===== hdl/dram_refresh_params.svh
// Timing counts, register offsets and field positions of the DRAM controller
`ifndef DRAM_REFRESH_PARAMS_SVH
`define DRAM_REFRESH_PARAMS_SVH
`define CLK_PERIOD_NS 10
`define ROW_HOLD_NS 30
`define COL_SETUP_NS 8
`define ROW_HOLD_CYC ((`ROW_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define COL_SETUP_CYC ((`COL_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FORCE_LEAD_EDGES 2
`define FORCE_LOW_PERIODS 2
`define CTRL_OFS 4'h0
`define STAT_OFS 4'h4
`define CTRL_HIDDEN_BIT 0
`define CTRL_FORCE_BIT 1
`define CTRL_RESET 2'h3
`define STAT_REQ_BIT 16
`define STAT_DONE_BIT 17
`define STAT_FDONE_BIT 18
`define STAT_STATE_LSB 20
`endif

// ===== hdl/dram_refresh_pkg.sv
// Types shared by the DRAM refresh and access controller
`default_nettype none
package dram_refresh_pkg;
    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_ROW = 3'h1,
        S_COL = 3'h3,
        S_CAS = 3'h2,
        S_HID = 3'h6,
        S_FWAIT = 3'h7,
        S_FRAS = 3'h5,
        S_FEND = 3'h4
    } ctl_state_type;
    typedef struct packed {
        logic [1:0] bank;
        logic [8:0] row;
        logic [8:0] col;
    } access_addr_type;
    typedef struct packed {
        logic [3:0] ras_n;
        logic cas_n;
        logic [8:0] addr;
    } dram_drive_type;
endpackage
`default_nettype wire

// ===== hdl/dram_refresh_access_ctrl.sv
// DRAM controller with auto access, hidden and forced refresh
`include "dram_refresh_params.svh"
`default_nettype none
// Summary of operation
// - Row and column latches and refresh row counter are nine bits each.
// - Falling row strobe input with select low starts access; strobes follow internally.
// - A deselected cycle inside a slot performs one hidden refresh, ending promptly.
// - Slot opens on refresh clock high; deselect then puts counter on address.
// - Hidden refresh: all row strobes follow input; counter steps on input rise.
// - At most one hidden refresh per refresh clock period.
// - No refresh in high phase: request goes low right after clock falls.
// - Second strobe clock falling edge after mode low: all row strobes low two periods.
// - At most one forced refresh per refresh clock period, about four periods.
// - Row address hold at least 30 ns, column setup at least 8 ns.
module dram_refresh_access_ctrl #(
    parameter int ADDR_W = 9
) (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic row_strobe_in_n_i,
    input wire logic select_n_i,
    input wire logic refresh_period_clock_i,
    input wire logic strobe_gen_clock_i,
    input wire logic refresh_mode_ctl_n_i,
    input wire dram_refresh_pkg::access_addr_type addr_i,
    output dram_refresh_pkg::dram_drive_type drive_o,
    output logic refresh_request_n_o,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o
);
    localparam logic [2:0] ROW_LAST = 3'(`ROW_HOLD_CYC - 1);
    localparam logic [2:0] COL_LAST = 3'(`COL_SETUP_CYC - 1);
    localparam logic [2:0] LEAD_LAST = 3'(`FORCE_LEAD_EDGES - 1);
    localparam logic [2:0] LOW_LAST = 3'(`FORCE_LOW_PERIODS - 1);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // Row strobe goes through the same two stages as select so that
    // the lead of select over the strobe survives the crossing.
    logic [2:0] meta_ff;
    logic [2:0] sync_ff;
    logic refresh_period_clock_s;
    logic sel_s;
    logic rs_s;
    logic refresh_period_clock_q_ff;
    logic rs_q_ff;
    logic strobe_gen_clock_q_ff;
    logic refresh_period_clock_rise;
    logic refresh_period_clock_fall;
    logic rs_fall;
    logic rs_rise;
    logic strobe_gen_clock_fall;

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            meta_ff <= 3'h7;
            sync_ff <= 3'h7;
        end
        else if (ce_i)
        begin
            meta_ff <= {refresh_period_clock_i, select_n_i,
                        row_strobe_in_n_i};
            sync_ff <= meta_ff;
        end
    end

    assign refresh_period_clock_s = sync_ff[2];
    assign sel_s = sync_ff[1];
    assign rs_s = sync_ff[0];

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            refresh_period_clock_q_ff <= 1'b1;
            rs_q_ff <= 1'b1;
            strobe_gen_clock_q_ff <= 1'b0;
        end
        else if (ce_i)
        begin
            refresh_period_clock_q_ff <= refresh_period_clock_s;
            rs_q_ff <= rs_s;
            strobe_gen_clock_q_ff <= strobe_gen_clock_i;
        end
    end

    assign refresh_period_clock_rise = refresh_period_clock_s && !refresh_period_clock_q_ff;
    assign refresh_period_clock_fall = !refresh_period_clock_s && refresh_period_clock_q_ff;
    assign rs_fall = !rs_s && rs_q_ff;
    assign rs_rise = rs_s && !rs_q_ff;
    assign strobe_gen_clock_fall = !strobe_gen_clock_i && strobe_gen_clock_q_ff;

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [1:0] ctrl_ff;
    logic ack_ff;
    logic [31:0] rdata_ff;
    logic [ADDR_W-1:0] cnt_ff;
    logic done_ff;
    logic fdone_ff;
    logic req_n_ff;
    dram_refresh_pkg::ctl_state_type state_ff;
    dram_refresh_pkg::ctl_state_type nxt_state;
    logic bus_req;

    assign bus_req = avs_read_i || avs_write_i;
    assign avs_waitrequest_o = bus_req && !ack_ff;
    assign avs_readdata_o = rdata_ff;

    function automatic logic [31:0] read_word(input logic [3:0] a);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (a == `CTRL_OFS)
            w[1:0] = ctrl_ff;
        else if (a == `STAT_OFS)
        begin
            w[ADDR_W-1:0] = cnt_ff;
            w[`STAT_REQ_BIT] = !req_n_ff;
            w[`STAT_DONE_BIT] = done_ff;
            w[`STAT_FDONE_BIT] = fdone_ff;
            w[`STAT_STATE_LSB+:3] = state_ff;
        end
        return w;
    endfunction

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ack_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end
        else if (ce_i)
        begin
            ack_ff <= bus_req && !ack_ff;
            if (avs_read_i && !ack_ff)
                rdata_ff <= read_word(avs_address_i);
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            ctrl_ff <= `CTRL_RESET;
        else if (ce_i && avs_write_i && ack_ff && avs_address_i == `CTRL_OFS)
            ctrl_ff <= avs_writedata_i[1:0];
    end

    // ------------------------------------------------------------
    // Access and refresh sequencer
    // ------------------------------------------------------------
    logic [2:0] tcnt_ff;
    logic [2:0] ecnt_ff;
    dram_refresh_pkg::access_addr_type lat_ff;
    dram_refresh_pkg::dram_drive_type nxt_drive;
    dram_refresh_pkg::access_addr_type acc_addr;
    logic slot_hidden;
    logic go_force;
    logic go_access;
    logic cnt_inc;

    assign slot_hidden = refresh_period_clock_s && sel_s && !done_ff &&
                         ctrl_ff[`CTRL_HIDDEN_BIT];
    assign go_force = !refresh_mode_ctl_n_i && !fdone_ff &&
                      ctrl_ff[`CTRL_FORCE_BIT];
    assign go_access = rs_fall && !sel_s && refresh_mode_ctl_n_i;
    // The first row cycle comes from the pins, because the latch only
    // takes the address at that same edge; otherwise the previously latched bank would flash.
    assign acc_addr = (state_ff == dram_refresh_pkg::S_IDLE) ? addr_i :
                      lat_ff;

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            dram_refresh_pkg::S_IDLE:
                if (go_force)
                    nxt_state = dram_refresh_pkg::S_FWAIT;
                else if (rs_fall && slot_hidden)
                    nxt_state = dram_refresh_pkg::S_HID;
                else if (go_access)
                    nxt_state = dram_refresh_pkg::S_ROW;
            dram_refresh_pkg::S_ROW:
                if (rs_s)
                    nxt_state = dram_refresh_pkg::S_IDLE;
                else if (tcnt_ff == ROW_LAST)
                    nxt_state = dram_refresh_pkg::S_COL;
            dram_refresh_pkg::S_COL:
                if (rs_s)
                    nxt_state = dram_refresh_pkg::S_IDLE;
                else if (tcnt_ff == COL_LAST)
                    nxt_state = dram_refresh_pkg::S_CAS;
            dram_refresh_pkg::S_CAS:
                if (rs_s)
                    nxt_state = dram_refresh_pkg::S_IDLE;
            dram_refresh_pkg::S_HID:
                if (rs_s)
                    nxt_state = dram_refresh_pkg::S_IDLE;
            dram_refresh_pkg::S_FWAIT:
                if (strobe_gen_clock_fall && ecnt_ff == LEAD_LAST)
                    nxt_state = dram_refresh_pkg::S_FRAS;
            dram_refresh_pkg::S_FRAS:
                if (strobe_gen_clock_fall && ecnt_ff == LOW_LAST)
                    nxt_state = dram_refresh_pkg::S_FEND;
            dram_refresh_pkg::S_FEND:
                if (refresh_mode_ctl_n_i)
                    nxt_state = dram_refresh_pkg::S_IDLE;
            default:
                nxt_state = dram_refresh_pkg::S_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            state_ff <= dram_refresh_pkg::S_IDLE;
        else if (ce_i)
            state_ff <= nxt_state;
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            tcnt_ff <= 3'h0;
            ecnt_ff <= 3'h0;
        end
        else if (ce_i)
        begin
            if (nxt_state != state_ff)
            begin
                tcnt_ff <= 3'h0;
                ecnt_ff <= 3'h0;
            end
            else
            begin
                tcnt_ff <= tcnt_ff + 3'h1;
                if (strobe_gen_clock_fall)
                    ecnt_ff <= ecnt_ff + 3'h1;
            end
        end
    end

    // Address is taken from the pins when the delayed strobe falls, so
    // the host keeps it stable for the two synchroniser cycles.
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            lat_ff <= '0;
        else if (ce_i && state_ff == dram_refresh_pkg::S_IDLE && go_access)
            lat_ff <= addr_i;
    end

    // ------------------------------------------------------------
    // Refresh bookkeeping
    // ------------------------------------------------------------
    assign cnt_inc = (state_ff == dram_refresh_pkg::S_HID && rs_s) ||
                     (state_ff == dram_refresh_pkg::S_FRAS &&
                      nxt_state == dram_refresh_pkg::S_FEND);

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            cnt_ff <= '0;
        else if (ce_i && cnt_inc)
            cnt_ff <= cnt_ff + 1'b1;
    end

    // Setting a flag wins over the slot-start clear of the same cycle.
    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            done_ff <= 1'b0;
        else if (ce_i)
        begin
            if (cnt_inc)
                done_ff <= 1'b1;
            else if (refresh_period_clock_rise)
                done_ff <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            fdone_ff <= 1'b0;
        else if (ce_i)
        begin
            if (state_ff == dram_refresh_pkg::S_FRAS)
                fdone_ff <= 1'b1;
            else if (refresh_period_clock_rise)
                fdone_ff <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            req_n_ff <= 1'b1;
        else if (ce_i)
        begin
            if (refresh_period_clock_fall && !done_ff)
                req_n_ff <= 1'b0;
            else if (state_ff == dram_refresh_pkg::S_FRAS)
                req_n_ff <= 1'b1;
        end
    end

    assign refresh_request_n_o = req_n_ff;

    // ------------------------------------------------------------
    // DRAM strobes and address
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_drive.ras_n = 4'hf;
        nxt_drive.cas_n = 1'b1;
        nxt_drive.addr = cnt_ff;
        case (nxt_state)
            dram_refresh_pkg::S_ROW:
            begin
                nxt_drive.ras_n[acc_addr.bank] = 1'b0;
                nxt_drive.addr = acc_addr.row;
            end
            dram_refresh_pkg::S_COL:
            begin
                nxt_drive.ras_n[lat_ff.bank] = 1'b0;
                nxt_drive.addr = lat_ff.col;
            end
            dram_refresh_pkg::S_CAS:
            begin
                nxt_drive.ras_n[lat_ff.bank] = 1'b0;
                nxt_drive.cas_n = 1'b0;
                nxt_drive.addr = lat_ff.col;
            end
            dram_refresh_pkg::S_HID:
                nxt_drive.ras_n = {4{rs_s}};
            dram_refresh_pkg::S_FRAS:
                nxt_drive.ras_n = 4'h0;
            dram_refresh_pkg::S_IDLE:
                if (!slot_hidden)
                    nxt_drive.addr = addr_i.row;
            default:
                nxt_drive.addr = cnt_ff;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            drive_o <= {4'hf, 1'b1, 9'h000};
        else if (ce_i)
            drive_o <= nxt_drive;
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i || !ce_i);

    property p_cnt_wrap;
        cnt_inc && cnt_ff == '1 |=> cnt_ff == '0;
    endproperty
    a_cnt_wrap: assert property (p_cnt_wrap) else $error("Counter wrap");
    property p_access_start;
        state_ff == dram_refresh_pkg::S_IDLE && go_access && !go_force
        |=> drive_o.ras_n != 4'hf && drive_o.cas_n;
    endproperty
    a_access_start: assert property (p_access_start)
        else $error("No row strobe on access");
    property p_row_hold;
        $rose(state_ff == dram_refresh_pkg::S_ROW) && !rs_s ##1 !rs_s[*2]
        |-> state_ff == dram_refresh_pkg::S_ROW;
    endproperty
    a_row_hold: assert property (p_row_hold)
        else $error("Row hold too short");
    property p_hidden_follow;
        state_ff == dram_refresh_pkg::S_HID && !rs_s |=> drive_o.ras_n == 4'h0;
    endproperty
    a_hidden_follow: assert property (p_hidden_follow)
        else $error("Strobes do not follow");
    property p_hidden_end;
        state_ff == dram_refresh_pkg::S_HID && rs_s
        |=> cnt_ff == $past(cnt_ff) + 1'b1 && done_ff;
    endproperty
    a_hidden_end: assert property (p_hidden_end)
        else $error("Hidden refresh not counted");
    property p_slot_addr;
        state_ff == dram_refresh_pkg::S_IDLE && slot_hidden && !go_force
        && !rs_fall |=> drive_o.addr == $past(cnt_ff);
    endproperty
    a_slot_addr: assert property (p_slot_addr)
        else $error("Counter not on address");
    property p_one_hidden;
        done_ff |-> nxt_state != dram_refresh_pkg::S_HID;
    endproperty
    a_one_hidden: assert property (p_one_hidden)
        else $error("Second hidden refresh");
    property p_request;
        refresh_period_clock_fall && !done_ff |=> !refresh_request_n_o;
    endproperty
    a_request: assert property (p_request) else $error("No request");
    property p_force_low;
        state_ff == dram_refresh_pkg::S_FRAS |-> drive_o.ras_n == 4'h0;
    endproperty
    a_force_low: assert property (p_force_low)
        else $error("Forced strobes high");
    property p_one_force;
        fdone_ff |-> nxt_state != dram_refresh_pkg::S_FWAIT;
    endproperty
    a_one_force: assert property (p_one_force)
        else $error("Second forced refresh");

    c_access: cover property (state_ff == dram_refresh_pkg::S_CAS);
    c_hidden: cover property (state_ff == dram_refresh_pkg::S_HID && rs_s);
    c_forced: cover property (state_ff == dram_refresh_pkg::S_FEND);
    c_bus: cover property (avs_write_i && !avs_waitrequest_o);
endmodule
`default_nettype wire

// ===== testbench/glue_bus_model.sv
// Processor bus and glue logic model driving the DRAM controller
`default_nettype none
module glue_bus_model (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic refresh_request_n_i,
    output logic row_strobe_in_n_o,
    output logic select_n_o,
    output logic refresh_mode_ctl_n_o,
    output logic strobe_gen_clock_o,
    output dram_refresh_pkg::access_addr_type addr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int hold_cnt = 0;
    logic cycle_extend_n;
    // Processor cycle is stretched only when a DRAM cycle meets a refresh
    assign cycle_extend_n = refresh_mode_ctl_n_o || select_n_o;
    logic [1:0] sg_div = 2'h0;
    initial
    begin
        row_strobe_in_n_o = 1'b1;
        select_n_o = 1'b1;
        refresh_mode_ctl_n_o = 1'b1;
        strobe_gen_clock_o = 1'b0;
        addr_o = '0;
    end
    // ----------------------------------------
    // Processor clock, free running at a quarter rate
    // ----------------------------------------
    always @(posedge ref_clk_i)
    begin
        sg_div <= sg_div + 2'h1;
        strobe_gen_clock_o <= sg_div[1];
    end
    // ----------------------------------------
    // Refresh acknowledge, held four processor periods
    // ----------------------------------------
    always @(posedge ref_clk_i)
    begin
        if (hold_cnt > 0)
        begin
            hold_cnt <= hold_cnt - 1;
            if (hold_cnt == 1)
                refresh_mode_ctl_n_o <= 1'b1;
        end
        else if (rstn_i && refresh_request_n_i === 1'b0)
        begin
            refresh_mode_ctl_n_o <= 1'b0;
            hold_cnt <= 16;
        end
    end
    task automatic start_access(input dram_refresh_pkg::access_addr_type a);
        // Precharge gap after a forced refresh before the next strobe
        for (int i = 0; i < 40 && !refresh_mode_ctl_n_o; i++)
            @(posedge ref_clk_i);
        repeat (4) @(posedge ref_clk_i);
        select_n_o <= 1'b0;
        addr_o <= a;
        @(posedge ref_clk_i);
        row_strobe_in_n_o <= 1'b0;
    endtask
    task automatic end_access();
        // A stretched cycle keeps its strobe low until the refresh is over
        for (int i = 0; i < 40 && !cycle_extend_n; i++)
            @(posedge ref_clk_i);
        @(posedge ref_clk_i);
        row_strobe_in_n_o <= 1'b1;
        select_n_o <= 1'b1;
        // Released address bus shows a changed pattern, not the old value
        addr_o <= ~addr_o;
    endtask
    task automatic set_strobe(input logic v);
        @(posedge ref_clk_i);
        row_strobe_in_n_o <= v;
    endtask
endmodule
`default_nettype wire

// ===== testbench/tb_dram_refresh_access_ctrl.sv
// Self-checking bench for the DRAM refresh and access controller
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
$display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module tb_dram_refresh_access_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic refresh_period_clock = 1'b1;
    logic ce = 1'b1;
    logic [3:0] avs_address_i = 4'h0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0000_0000;
    wire logic row_strobe_n;
    wire logic select_n;
    wire logic mode_n;
    wire logic sg_clk;
    wire dram_refresh_pkg::access_addr_type addr;
    dram_refresh_pkg::dram_drive_type drive_o;
    logic refresh_request_n_o;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic [31:0] rd;
    int error_cnt = 0;
    int check_count = 0;
    int n;
    initial
    begin
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    dram_refresh_access_ctrl DUT (
        .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ce_i(ce),
        .row_strobe_in_n_i(row_strobe_n), .select_n_i(select_n),
        .refresh_period_clock_i(refresh_period_clock), .strobe_gen_clock_i(sg_clk),
        .refresh_mode_ctl_n_i(mode_n), .addr_i(addr), .drive_o(drive_o),
        .refresh_request_n_o(refresh_request_n_o),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o)
    );
    glue_bus_model glue (
        .ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
        .refresh_request_n_i(refresh_request_n_o),
        .row_strobe_in_n_o(row_strobe_n), .select_n_o(select_n),
        .refresh_mode_ctl_n_o(mode_n), .strobe_gen_clock_o(sg_clk),
        .addr_o(addr)
    );
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic bus(input logic wr, input logic [3:0] a,
        input logic [31:0] d);
        @(posedge ref_clk_i);
        avs_address_i <= a;
        avs_read_i <= !wr;
        avs_write_i <= wr;
        avs_writedata_i <= d;
        for (int i = 0; i <= 20; i++)
        begin
            @(posedge ref_clk_i);
            if (avs_waitrequest_o === 1'b0)
                break;
            if (i == 20)
            begin
                error_cnt++;
                finish_test();
            end
        end
        rd = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        #1;
    endtask
    // Waits for strobes (which 0) or request line (which 1) to reach v
    task automatic wait_sig(input int which, input logic [3:0] v);
        logic [3:0] got;
        for (int i = 0; i < 30; i++)
        begin
            got = which ? {3'h0, refresh_request_n_o} : drive_o.ras_n;
            if (got === v)
                return;
            tick(1);
        end
        error_cnt++;
        finish_test();
    endtask
    task automatic end_test(input string s);
        $display("test %s finished", s);
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (4) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        tick(2);
        bus(1'b0, 4'h0, 32'h0);
        `CHK(rd[1:0], 2'h3)
        bus(1'b1, 4'hC, 32'hFFFF_FFFF);
        bus(1'b0, 4'hC, 32'h0);
        `CHK(rd, 32'h0000_0000)
        bus(1'b1, 4'h4, 32'h0000_01FF);
        bus(1'b0, 4'h4, 32'h0);
        `CHK(rd[8:0], 9'h000)
        end_test("registers");
        glue.start_access('{2'h2, 9'h1A5, 9'h0C3});
        wait_sig(0, 4'hB);
        `CHK(drive_o.addr, 9'h1A5)
        tick(2);
        `CHK(drive_o.addr, 9'h1A5)
        tick(1);
        `CHK(drive_o.addr, 9'h0C3)
        `CHK(drive_o.cas_n, 1'b1)
        tick(1);
        `CHK(drive_o.cas_n, 1'b0)
        glue.end_access();
        tick(4);
        `CHK(drive_o.ras_n, 4'hF)
        end_test("access");
        `CHK(drive_o.addr, 9'h000)
        glue.set_strobe(1'b0);
        wait_sig(0, 4'h0);
        glue.set_strobe(1'b1);
        tick(4);
        `CHK(drive_o.ras_n, 4'hF)
        bus(1'b0, 4'h4, 32'h0);
        `CHK(rd[8:0], 9'h001)
        `CHK(rd[17], 1'b1)
        glue.set_strobe(1'b0);
        tick(6);
        `CHK(drive_o.ras_n, 4'hF)
        glue.set_strobe(1'b1);
        tick(3);
        refresh_period_clock <= 1'b0;
        tick(10);
        `CHK(refresh_request_n_o, 1'b1)
        end_test("hidden");
        bus(1'b1, 4'h0, 32'h0000_0002);
        bus(1'b0, 4'h0, 32'h0);
        `CHK(rd[1:0], 2'h2)
        refresh_period_clock <= 1'b1;
        tick(6);
        glue.set_strobe(1'b0);
        tick(6);
        `CHK(drive_o.ras_n, 4'hF)
        glue.set_strobe(1'b1);
        tick(3);
        refresh_period_clock <= 1'b0;
        wait_sig(1, 4'h0);
        wait_sig(0, 4'h0);
        n = 0;
        while (drive_o.ras_n === 4'h0 && n < 20)
        begin
            n++;
            tick(1);
        end
        `CHK(n, 8)
        bus(1'b0, 4'h4, 32'h0);
        `CHK(rd[8:0], 9'h002)
        `CHK(rd[18], 1'b1)
        tick(20);
        `CHK(refresh_request_n_o, 1'b1)
        `CHK(drive_o.ras_n, 4'hF)
        bus(1'b1, 4'h0, 32'h0000_0003);
        end_test("forced");
        // Clock enable low: a whole access on the pins must leave no trace
        ce <= 1'b0;
        glue.start_access('{2'h1, 9'h055, 9'h0AA});
        tick(8);
        `CHK(drive_o.ras_n, 4'hF)
        `CHK(drive_o.addr, 9'h05A)
        glue.end_access();
        tick(2);
        ce <= 1'b1;
        tick(6);
        `CHK(drive_o.ras_n, 4'hF)
        `CHK(drive_o.addr, 9'h1AA)
        end_test("enable");
        finish_test();
    end
endmodule
`default_nettype wire
